// >>> bench/gpc_pins_model.sv
// far-side model: external pin levels and event link pulses
`default_nettype none
module gpc_pins_model (
   input  wire gpc_pkg::gpc_pins_t pins,
   input  wire logic               hclk,
   input  wire logic [15:0]        ext_lvl,
   output logic [15:0]             pin_in,
   output logic                    port_event_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   import gpc_pkg::*;
   // driven pins read back their own level, the rest the outside level
   assign pin_in = (pins.dir & pins.out) | (~pins.dir & ext_lvl);
   initial port_event_pulse = 1'b0;
   // one clock wide, launched just after an edge
   task automatic fire;
      port_event_pulse <= 1'b1;
      @(posedge hclk);
      port_event_pulse <= 1'b0;
   endtask : fire
endmodule : gpc_pins_model
`default_nettype wire

// >>> bench/gpio_port_control_tb.sv
// self-checking bench of the port control block
`include "gpc_params.svh"
`default_nettype none
module gpio_port_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import gpc_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] pin_in, ext_lvl, evt_lvl, psel;
   logic        pulse;
   gpc_pins_t   pins;
   int          bad_count, check_count;
   ////////////////////////////////////////////////////////////////
   // pin 0 input only, so its set bit must do nothing
   gpc_port #(.OUT_CAPABLE(16'hfffe)) u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pin_in(pin_in), .event_input_level_bits(evt_lvl),
      .port_event_pulse(pulse), .pins(pins), .peripheral_select_bit(psel));
   gpc_pins_model u_far (.pins(pins), .hclk(hclk), .ext_lvl(ext_lvl),
      .pin_in(pin_in), .port_event_pulse(pulse));
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   // single transfer; waits on hready rather than assuming zero wait
   task automatic bus(input logic [11:0] a, input logic w, input logic [2:0] s,
                      input logic [31:0] d);
      haddr <= {20'h0, a};
      hwrite <= w;
      hsize <= s;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic stop_test;
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////
   task automatic t_reg;
      check(pins, 32'h0);
      bus(`GPC_OFS_DIR_OUT, 1'b1, 3'd2, 32'h1234_00f0);
      bus(`GPC_OFS_DIR_OUT + 12'h2, 1'b1, 3'd1, 32'h5a5a_0000);
      bus(`GPC_OFS_DIR_OUT, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h5a5a_00f0);
      check(pins, {16'h00f0, 16'h5a5a});
      bus(12'h020, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h0);
   endtask : t_reg
   // only undriven pins are compared against the outside level
   task automatic t_in;
      ext_lvl <= 16'h3c3c;
      evt_lvl <= 16'h8001;
      bus(`GPC_OFS_INPUT, 1'b1, 3'd2, 32'hffff_ffff);
      bus(`GPC_OFS_INPUT, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h8001_3c5c);
   endtask : t_in
   task automatic t_sc;
      bus(`GPC_OFS_SET_CLEAR, 1'b1, 3'd2, 32'h0202_0305);
      bus(`GPC_OFS_SET_CLEAR, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h0);
      check(pins.out, 16'h595c);
      bus(`GPC_OFS_SET_CLEAR, 1'b1, 3'd2, 32'h0);
      bus(`GPC_OFS_SET_CLEAR + 12'h2, 1'b1, 3'd1, 32'h0010_0000);
      bus(`GPC_OFS_DIR_OUT, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h594c_00f0);
   endtask : t_sc
   task automatic t_evt;
      bus(`GPC_OFS_EVT_SC, 1'b1, 3'd2, 32'h0044_2006);
      bus(`GPC_OFS_EVT_SC, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h0044_2006);
      u_far.fire();
      #1;
      check(pins.out, 16'h790a);
      @(posedge hclk);
      bus(`GPC_OFS_EVT_SC + 12'h2, 1'b1, 3'd1, 32'h0);
      bus(`GPC_OFS_EVT_SC, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h0000_2006);
   endtask : t_evt
   task automatic t_pfs;
      bus(`GPC_OFS_PFS_BASE + 12'hc, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h3);
      bus(`GPC_OFS_PFS_BASE + 12'hc, 1'b1, 3'd0, 32'h6);
      bus(`GPC_OFS_DIR_OUT, 1'b0, 3'd2, 32'h0);
      check(rd, 32'h7902_00f8);
      bus(`GPC_OFS_PFS_BASE + 12'hc, 1'b1, 3'd2, 32'h0001_0004);
      bus(`GPC_OFS_PFS_BASE + 12'hc, 1'b0, 3'd1, 32'h0);
      check(rd, 32'h0001_0004);
      check(psel, 16'h0008);
   endtask : t_pfs
   ////////////////////////////////////////////////////////////////
   initial begin
      {hresetn, hwrite, htrans, hsize, haddr, hwdata} = '0;
      hsel = 1'b1;
      ext_lvl = 16'h0;
      evt_lvl = 16'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reg();
      t_in();
      t_sc();
      t_evt();
      t_pfs();
      stop_test();
   end
   // whole run is well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      stop_test();
   end
endmodule : gpio_port_control_tb
`default_nettype wire

// >>> src/gpc_params.svh
// offsets, field positions and reset values of the port control block
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_OFS_DIR_OUT    12'h000
`define GPC_OFS_INPUT      12'h004
`define GPC_OFS_SET_CLEAR  12'h008
`define GPC_OFS_EVT_SC     12'h00c
`define GPC_OFS_PFS_BASE   12'h040
`define GPC_OFS_PFS_LAST   12'h07c
`define GPC_WORD_MASK      12'hffc
`define GPC_PFS_DIR_BIT    2
`define GPC_PFS_OUT_BIT    0
`define GPC_PFS_IN_BIT     1
`define GPC_PFS_PMR_BIT    16
`define GPC_PIN_MASK       16'hffff
`define GPC_SET_MASK       16'hffff
`define GPC_RST_HALF       16'h0000
`define GPC_ADDR_LSB       2
`define GPC_PFS_IDX_W      4
`endif

// >>> src/gpc_pkg.sv
// types shared by the port control block
`default_nettype none
package gpc_pkg;
   typedef struct packed {
      logic [15:0] dir;
      logic [15:0] out;
   } gpc_pins_t;
   typedef struct packed {
      logic [11:0] addr;
      logic        write;
      logic [2:0]  size;
   } gpc_req_t;
endpackage : gpc_pkg
`default_nettype wire

// >>> src/gpc_port.sv
// gpio port control: direction, output level, set/clear and event set/clear registers
// Behaviour
// - direction in bits 15:0, output level in 31:16, halves writable alone
// - one word access reads or writes direction and output together
// - every pin has its own direction bit
// - input register: pin levels low half, event input levels high half, read only
// - pin level bits follow the pin whatever direction or peripheral select
// - write-only set/clear register: low half sets, high half clears outputs
// - writing one to a set bit drives that output level to one unless a clear hits the same bit in that cycle
// - event set/clear register readable and writable, word or half access
// - port event pulse sets and clears outputs selected by event register
// - bits of absent pins are reserved; software writes zero
// - set bit of an input-only pin is reserved and has no effect
// - function select register accessible as word, low half or low byte
// - function select direction, input and output bits mirror port-wide bits
`include "gpc_params.svh"
`default_nettype none
module gpc_port #(
   parameter logic [15:0] PIN_EXIST  = `GPC_PIN_MASK,
   parameter logic [15:0] OUT_CAPABLE = `GPC_SET_MASK
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic [15:0]        pin_in,
   input  wire logic [15:0]        event_input_level_bits,
   input  wire logic               port_event_pulse,
   output gpc_pkg::gpc_pins_t      pins,
   output logic [15:0]             peripheral_select_bit
);
   import gpc_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // byte-lane helper: which bytes of the word a transfer touches
   function automatic logic [3:0] lanes(input logic [1:0] a, input logic [2:0] sz);
      logic [3:0] l;
      l = 4'h0;
      unique case (sz)
         3'h0:    l = 4'h1 << a;
         3'h1:    l = a[1] ? 4'hc : 4'h3;
         default: l = 4'hf;
      endcase
      return l;
   endfunction : lanes

   function automatic logic [15:0] half(input logic [31:0] d, input logic [3:0] l,
                                        input logic hi, input logic [15:0] old);
      logic [15:0] r;
      r = old;
      if (hi) begin
         if (l[2]) r[7:0]  = d[23:16];
         if (l[3]) r[15:8] = d[31:24];
      end else begin
         if (l[0]) r[7:0]  = d[7:0];
         if (l[1]) r[15:8] = d[15:8];
      end
      return r;
   endfunction : half

   // word offset of a register address, byte lanes stripped
   function automatic logic [11:0] word_ofs(input logic [11:0] a);
      return a & `GPC_WORD_MASK;
   endfunction : word_ofs

   // true inside the per-pin function select window
   function automatic logic in_pfs(input logic [11:0] a);
      return (a >= `GPC_OFS_PFS_BASE) && (a <= `GPC_OFS_PFS_LAST);
   endfunction : in_pfs

   ////////////////////////////////////////////////////////////////////
   gpc_req_t    req;
   logic        wr_pend;
   logic [15:0] dir_bits;
   logic [15:0] out_bits;
   logic [15:0] evt_set;
   logic [15:0] evt_clr;
   logic [15:0] pin_level_bits;
   logic [3:0]  wl;
   logic        hit_pfs;
   logic [3:0]  pfs_idx;
   logic [15:0] sw_set;
   logic [15:0] sw_clr;
   logic [15:0] next_out;
   logic [15:0] next_dir;
   logic [15:0] next_pmr;
   logic [15:0] all_set;
   logic [15:0] all_clr;
   logic [15:0] sw_set_eff;
   logic [15:0] evt_set_eff;
   logic [11:0] rd_ofs;
   logic        pmr_wr_bit;
   logic        pfs_dir_bit;

   wire   take = hsel & hready & htrans[1];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign pin_level_bits = pin_in & PIN_EXIST;
   assign pins.dir = dir_bits;
   assign pins.out = out_bits;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         req     <= '0;
      end else begin
         wr_pend <= take & hwrite;
         if (take) begin
            req.addr  <= haddr[11:0];
            req.write <= hwrite;
            req.size  <= hsize;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write data phase decode, plus the read offset from the address phase
   assign wl          = lanes(req.addr[1:0], req.size);
   assign hit_pfs     = in_pfs(req.addr);
   assign pfs_idx     = req.addr[`GPC_ADDR_LSB +: `GPC_PFS_IDX_W];
   assign pmr_wr_bit  = hwdata[`GPC_PFS_PMR_BIT];
   assign pfs_dir_bit = hwdata[`GPC_PFS_DIR_BIT];
   assign rd_ofs      = word_ofs(haddr[11:0]);
   // what a software or event strobe should leave behind, for the checks
   assign sw_set_eff  = sw_set & ~sw_clr & OUT_CAPABLE & PIN_EXIST;
   assign evt_set_eff = evt_set & ~evt_clr & OUT_CAPABLE & PIN_EXIST;

   // software writes into direction, output and select bits
   always_comb begin
      sw_set   = 16'h0000;
      sw_clr   = 16'h0000;
      next_dir = dir_bits;
      next_out = out_bits;
      next_pmr = peripheral_select_bit;
      if (wr_pend) begin
         unique case (word_ofs(req.addr))
            `GPC_OFS_DIR_OUT: begin
               next_dir = half(hwdata, wl, 1'b0, dir_bits);
               next_out = half(hwdata, wl, 1'b1, out_bits);
            end
            `GPC_OFS_SET_CLEAR: begin
               sw_set = half(hwdata, wl, 1'b0, 16'h0000);
               sw_clr = half(hwdata, wl, 1'b1, 16'h0000);
            end
            default: begin
               if (hit_pfs) begin
                  // lane 0 holds out and dir, lane 2 the select bit
                  if (wl[0]) begin
                     next_dir[pfs_idx] = hwdata[`GPC_PFS_DIR_BIT];
                     next_out[pfs_idx] = hwdata[`GPC_PFS_OUT_BIT];
                  end
                  if (wl[2]) begin
                     next_pmr[pfs_idx] = hwdata[`GPC_PFS_PMR_BIT];
                  end
               end
            end
         endcase
      end
      // merge both sources first, so a clear from either side beats any set
      all_set  = sw_set | (port_event_pulse ? evt_set : 16'h0000);
      all_set  = all_set & OUT_CAPABLE;
      all_clr  = sw_clr | (port_event_pulse ? evt_clr : 16'h0000);
      next_out = (next_out | all_set) & ~all_clr;
      next_out = next_out & PIN_EXIST;
      next_dir = next_dir & PIN_EXIST;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_bits <= `GPC_RST_HALF;
         out_bits <= `GPC_RST_HALF;
         peripheral_select_bit <= `GPC_RST_HALF;
      end else begin
         dir_bits <= next_dir;
         out_bits <= next_out;
         peripheral_select_bit <= next_pmr & PIN_EXIST;
      end
   end

   // event selection register, plain storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_set <= `GPC_RST_HALF;
         evt_clr <= `GPC_RST_HALF;
      end else if (wr_pend && word_ofs(req.addr) == `GPC_OFS_EVT_SC) begin
         evt_set <= half(hwdata, wl, 1'b0, evt_set) & PIN_EXIST;
         evt_clr <= half(hwdata, wl, 1'b1, evt_clr) & PIN_EXIST;
      end
   end

   // one pin's select word, built from the port-wide bits
   function automatic logic [31:0] pfs_word(input logic [3:0] i);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`GPC_PFS_OUT_BIT] = out_bits[i];
      w[`GPC_PFS_IN_BIT]  = pin_level_bits[i];
      w[`GPC_PFS_DIR_BIT] = dir_bits[i];
      w[`GPC_PFS_PMR_BIT] = peripheral_select_bit[i];
      return w;
   endfunction : pfs_word

   ////////////////////////////////////////////////////////////////////
   // read data: registered on the address phase, zero-wait slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         // write-only set/clear and unmapped words fall through and read zero
         hrdata <= 32'h0000_0000;
         if (rd_ofs == `GPC_OFS_DIR_OUT) begin
            hrdata <= {out_bits, dir_bits};
         end else if (rd_ofs == `GPC_OFS_INPUT) begin
            hrdata <= {event_input_level_bits, pin_level_bits};
         end else if (rd_ofs == `GPC_OFS_EVT_SC) begin
            hrdata <= {evt_clr, evt_set};
         end else if (in_pfs(haddr[11:0])) begin
            // mirrors the port-wide bits; pick by pin index
            hrdata <= pfs_word(haddr[`GPC_ADDR_LSB +: `GPC_PFS_IDX_W]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks on the register effects
   chk_set_drives_out: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_SET_CLEAR && !port_event_pulse)
      |=> (out_bits & $past(sw_set_eff)) == $past(sw_set_eff))
      else $error("set bit did not drive output");

   chk_clear_wins: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_SET_CLEAR)
      |=> (out_bits & $past(sw_clr)) == 16'h0000)
      else $error("clear bit did not clear output");

   chk_event_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      port_event_pulse
      |=> (out_bits & $past(evt_clr)) == 16'h0000)
      else $error("event clear ignored");

   chk_event_set: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (port_event_pulse && !wr_pend)
      |=> (out_bits & $past(evt_set_eff)) == $past(evt_set_eff))
      else $error("event set ignored");

   chk_no_event_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!port_event_pulse && !wr_pend)
      |=> $stable(out_bits) && $stable(dir_bits))
      else $error("outputs moved with no cause");

   chk_input_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && rd_ofs == `GPC_OFS_INPUT)
      |=> hrdata == {$past(event_input_level_bits), $past(pin_level_bits)})
      else $error("input read wrong");

   chk_dir_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && rd_ofs == `GPC_OFS_DIR_OUT)
      |=> hrdata == {$past(out_bits), $past(dir_bits)})
      else $error("dir/out read wrong");

   chk_input_only: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!OUT_CAPABLE[0] && !out_bits[0] && !(wr_pend && hit_pfs)
       && !(wr_pend && word_ofs(req.addr) == `GPC_OFS_DIR_OUT))
      |=> !out_bits[0]) else $error("input-only pin set");

   chk_absent_pins: assert property (
      @(posedge hclk) disable iff (!hresetn)
      ((out_bits | dir_bits) & ~PIN_EXIST) == 16'h0000)
      else $error("absent pin bit set");

   chk_evt_reg_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && rd_ofs == `GPC_OFS_EVT_SC)
      |=> hrdata == {$past(evt_clr), $past(evt_set)})
      else $error("event register read wrong");

   chk_sc_read_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && rd_ofs == `GPC_OFS_SET_CLEAR)
      |=> hrdata == 32'h0000_0000)
      else $error("write-only register read back data");

   chk_word_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_DIR_OUT && wl == 4'hf && !port_event_pulse)
      |=> dir_bits == (16'($past(hwdata)) & PIN_EXIST)
          && out_bits == (16'($past(hwdata) >> 16) & PIN_EXIST))
      else $error("word write did not land in both halves");

   chk_low_half_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_DIR_OUT && wl == 4'h3 && !port_event_pulse)
      |=> $stable(out_bits))
      else $error("direction half write touched outputs");

   chk_high_half_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_DIR_OUT && wl == 4'hc)
      |=> $stable(dir_bits))
      else $error("output half write touched direction");

   chk_sc_no_store: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_SET_CLEAR)
      |=> $stable(dir_bits) && $stable(peripheral_select_bit))
      else $error("set/clear write changed other state");

   chk_evt_reg_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_EVT_SC && wl == 4'hf)
      |=> evt_set == (16'($past(hwdata)) & PIN_EXIST))
      else $error("event select write lost");

   chk_evt_reg_quiet: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && word_ofs(req.addr) == `GPC_OFS_EVT_SC && !port_event_pulse)
      |=> $stable(out_bits))
      else $error("event select write moved outputs");

   chk_pfs_dir_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && hit_pfs && wl[0])
      |=> dir_bits[$past(pfs_idx)] == ($past(pfs_dir_bit) & PIN_EXIST[$past(pfs_idx)]))
      else $error("select register direction bit lost");

   chk_pmr_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && hit_pfs && wl[2])
      |=> peripheral_select_bit[$past(pfs_idx)]
          == ($past(pmr_wr_bit) & PIN_EXIST[$past(pfs_idx)]))
      else $error("peripheral select bit lost");
endmodule : gpc_port
`default_nettype wire
